// file: core/lscc_pkg.sv
package lscc_pkg;

   // Register indices reachable through the command byte
   localparam logic [4:0] CTRL_IDX = 5'h00;
   localparam logic [4:0] TIMER_LO_IDX = 5'h18;
   localparam logic [4:0] TIMER_HI_IDX = 5'h19;

   // Command byte layout
   localparam int CMD_SEL_BIT = 7;
   localparam int TRANS_HI_BIT = 6;
   localparam int TRANS_LO_BIT = 5;
   localparam int ADDR_HI_BIT = 4;
   localparam logic [1:0] TRANS_REPEAT = 2'h0;
   localparam logic [1:0] TRANS_AUTO = 2'h1;
   localparam logic [1:0] TRANS_SPECIAL = 2'h3;

   // Special function codes
   localparam logic [4:0] SF_INT_CLEAR = 5'h01;
   localparam logic [4:0] SF_STOP_MANUAL = 5'h02;
   localparam logic [4:0] SF_START_MANUAL = 5'h03;

   // Control register layout
   localparam int POWER_BIT = 0;
   localparam int ADC_EN_BIT = 1;
   localparam int ADC_VALID_BIT = 4;
   localparam int INTR_BIT = 5;
   localparam logic [7:0] CTRL_WR_MASK = 8'h03;

   // Values after reset and special settings
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] INTEGRATION_TIME_SETTING_MANUAL = 8'h00;

   // Power-up settling before the converters may be enabled
   localparam int CLK_MHZ = 100;
   localparam int PWR_WAIT_MS = 2;
   localparam int PWR_WAIT_CYC = PWR_WAIT_MS * 1000 * CLK_MHZ;

   // Host request kinds
   typedef enum logic [1:0] {
      LSCC_REQ_WRITE = 2'b00,
      LSCC_REQ_READ = 2'b01,
      LSCC_REQ_SPECIAL = 2'b10
   } lscc_req_t;

   function automatic logic lscc_is_special(input logic [7:0] cmd);
      lscc_is_special = (cmd[TRANS_HI_BIT:TRANS_LO_BIT] == TRANS_SPECIAL);
   endfunction : lscc_is_special

endpackage : lscc_pkg

// file: core/lscc_link_if.sv
`timescale 1ns/1ps
interface lscc_link_if;
   logic cmd_stb;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] wdata;
   logic rd_valid;
   logic [7:0] rdata;
   logic irq;

   modport dev (
      input cmd_stb,
      input wr_stb,
      input rd_stb,
      input wdata,
      output rd_valid,
      output rdata,
      output irq
   );

   modport host (
      output cmd_stb,
      output wr_stb,
      output rd_stb,
      output wdata,
      input rd_valid,
      input rdata,
      input irq
   );
endinterface : lscc_link_if

// file: core/lscc_dev.sv
`timescale 1ns/1ps
// How it works
// - Low five command bits index target register
// - Transaction 11 makes them a special code
// - Code 00001 clears pending interrupt once
// - Code 00010 stops manual integration when timing zero
// - Code 00011 starts manual integration when timing zero
// - Manual integration length readable in timer registers
// - Control bit 0 powers device on/off
// - Control bit 1 enables or disables both converters
// - Control bit 4 reads integration complete
// - Control bit 5 reads interrupt asserted
// - Host writes zero to reserved control bits
// - Command and control registers reset to zero
// - Host sets power and enable for conversions
// - Host waits 2 ms power before enable
// - Host configures registers before enabling converters; lscc_host still writes them later and raises cfg_while_running
// - Host sets bit 7 on command bytes
// - Type 00 repeats register, 01 advances index
// - Timing zero selects manually timed integration
module lscc_dev
   import lscc_pkg::*;
#(
   parameter int TIMER_W = 16
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   lscc_link_if.dev link,
   input wire logic [7:0] integration_time_setting,
   input wire logic adc_done,
   input wire logic int_event,
   input wire logic [7:0] ext_rdata,
   output logic power_on,
   output logic adc_enable,
   output logic manual_active,
   output logic int_out,
   output logic [4:0] reg_index,
   output logic ext_wr,
   output logic [4:0] ext_idx,
   output logic [7:0] ext_wdata,
   output logic [TIMER_W-1:0] manual_time
);

   if (TIMER_W < 9 || TIMER_W > 16) begin : g_bad_timer_w
      $error("TIMER_W must lie between 9 and 16");
   end

   typedef struct packed {
      logic [7:0] cmd;
      logic [4:0] idx;
      logic power;
      logic adc_en;
      logic adc_valid;
      logic irq;
      logic manual;
      logic [TIMER_W-1:0] timer;
      logic rd_valid;
      logic [7:0] rdata;
      logic ext_wr;
      logic [4:0] ext_idx;
      logic [7:0] ext_wdata;
   } lscc_dev_state_t;

   localparam logic [TIMER_W-1:0] TIMER_MAX = '1;

   lscc_dev_state_t s_r;
   lscc_dev_state_t s_nxt;

   function automatic logic [7:0] ctrl_image(input lscc_dev_state_t s);
      logic [7:0] v;
      v = CTRL_RESET;
      v[POWER_BIT] = s.power;
      v[ADC_EN_BIT] = s.adc_en;
      v[ADC_VALID_BIT] = s.adc_valid;
      v[INTR_BIT] = s.irq;
      ctrl_image = v;
   endfunction : ctrl_image

   function automatic logic [7:0] read_mux(input lscc_dev_state_t s, input logic [7:0] ext);
      logic [15:0] t;
      t = 16'(s.timer);
      case (s.idx)
         CTRL_IDX: begin
            read_mux = ctrl_image(s);
         end
         TIMER_LO_IDX: begin
            read_mux = t[7:0];
         end
         TIMER_HI_IDX: begin
            read_mux = t[15:8];
         end
         default: begin
            read_mux = ext;
         end
      endcase
   endfunction : read_mux

   logic clr_irq;
   logic set_valid;
   logic clr_valid;
   logic manual_mode;
   logic advance;

   always_comb begin
      s_nxt = s_r;
      s_nxt.rd_valid = 1'b0;
      s_nxt.ext_wr = 1'b0;
      clr_irq = 1'b0;
      set_valid = 1'b0;
      clr_valid = 1'b0;
      advance = 1'b0;
      manual_mode = (integration_time_setting == INTEGRATION_TIME_SETTING_MANUAL);

      // Manual integration timer runs while integrating, saturating
      if (s_r.manual && s_r.timer != TIMER_MAX) begin
         s_nxt.timer = s_r.timer + 1'b1;
      end

      if (link.cmd_stb) begin
         s_nxt.cmd = link.wdata;
         // Special codes leave the register index untouched
         if (!lscc_is_special(link.wdata)) begin
            s_nxt.idx = link.wdata[ADDR_HI_BIT:0];
         end
         if (lscc_is_special(link.wdata)) begin
            case (link.wdata[ADDR_HI_BIT:0])
               SF_INT_CLEAR: begin
                  clr_irq = 1'b1;
               end
               SF_STOP_MANUAL: begin
                  if (manual_mode && s_r.manual) begin
                     s_nxt.manual = 1'b0;
                     set_valid = 1'b1;
                  end
               end
               SF_START_MANUAL: begin
                  if (manual_mode && !s_r.manual) begin
                     s_nxt.manual = 1'b1;
                     s_nxt.timer = '0;
                  end
               end
               default: begin
               end
            endcase
         end
      end else if (link.wr_stb && !lscc_is_special(s_r.cmd)) begin
         advance = 1'b1;
         if (s_r.idx == CTRL_IDX) begin
            s_nxt.power = link.wdata[POWER_BIT];
            s_nxt.adc_en = link.wdata[ADC_EN_BIT];
            if (!link.wdata[ADC_EN_BIT] || !link.wdata[POWER_BIT]) begin
               clr_valid = 1'b1;
            end
         end else begin
            s_nxt.ext_wr = 1'b1;
            s_nxt.ext_idx = s_r.idx;
            s_nxt.ext_wdata = link.wdata;
         end
      end else if (link.rd_stb && !lscc_is_special(s_r.cmd)) begin
         advance = 1'b1;
         s_nxt.rd_valid = 1'b1;
         s_nxt.rdata = read_mux(s_r, ext_rdata);
      end

      // Auto-increment advances, repeated byte stays put
      if (advance && s_r.cmd[TRANS_HI_BIT:TRANS_LO_BIT] == TRANS_AUTO) begin
         s_nxt.idx = s_r.idx + 5'h01;
      end

      // Set wins over clear on both sticky flags
      s_nxt.irq = (s_r.irq && !clr_irq) || int_event;
      s_nxt.adc_valid = (s_r.adc_valid && !clr_valid) || adc_done || set_valid;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.rd_valid = s_r.rd_valid;
   assign link.rdata = s_r.rdata;
   assign link.irq = s_r.irq;
   assign power_on = s_r.power;
   assign adc_enable = s_r.adc_en;
   assign manual_active = s_r.manual;
   assign int_out = s_r.irq;
   assign reg_index = s_r.idx;
   assign ext_wr = s_r.ext_wr;
   assign ext_idx = s_r.ext_idx;
   assign ext_wdata = s_r.ext_wdata;
   assign manual_time = s_r.timer;

endmodule : lscc_dev

// file: core/lscc_host.sv
`timescale 1ns/1ps
module lscc_host
   import lscc_pkg::*;
#(
   parameter int PWR_WAIT = PWR_WAIT_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   lscc_link_if.host link,
   input wire logic req_valid,
   input wire lscc_req_t req_kind,
   input wire logic [4:0] req_addr,
   input wire logic [7:0] req_data,
   output logic req_ready,
   output logic resp_valid,
   output logic [7:0] resp_data,
   output logic irq_level,
   output logic cfg_while_running
);

   if (PWR_WAIT < 1) begin : g_bad_wait
      $error("PWR_WAIT must be at least 1");
   end

   localparam int CNT_W = $clog2(PWR_WAIT + 1);
   localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(PWR_WAIT);

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_PRE_CMD = 3'b001,
      H_PRE_DATA = 3'b010,
      H_WAIT_PWR = 3'b011,
      H_CMD = 3'b100,
      H_DATA = 3'b101,
      H_RD = 3'b110,
      H_WAIT_RD = 3'b111
   } lscc_hstate_t;

   typedef struct packed {
      lscc_hstate_t st;
      lscc_req_t kind;
      logic [4:0] addr;
      logic [7:0] data;
      logic [CNT_W-1:0] cnt;
      logic pwr_shadow;
      logic adc_shadow;
      logic cmd_stb;
      logic wr_stb;
      logic rd_stb;
      logic [7:0] wdata;
      logic ready;
      logic resp_valid;
      logic [7:0] resp_data;
      logic irq;
      logic cfg_warn;
   } lscc_host_state_t;

   lscc_host_state_t s_r;
   lscc_host_state_t s_nxt;

   function automatic logic [7:0] cmd_byte(input logic [4:0] a, input logic [1:0] trans);
      logic [7:0] v;
      v = 8'h00;
      v[CMD_SEL_BIT] = 1'b1;
      v[TRANS_HI_BIT:TRANS_LO_BIT] = trans;
      v[ADDR_HI_BIT:0] = a;
      cmd_byte = v;
   endfunction : cmd_byte

   logic pwr_ok;
   logic adc_req;
   logic [7:0] ctrl_val;

   always_comb begin
      s_nxt = s_r;
      s_nxt.cmd_stb = 1'b0;
      s_nxt.wr_stb = 1'b0;
      s_nxt.rd_stb = 1'b0;
      s_nxt.resp_valid = 1'b0;
      s_nxt.irq = link.irq;
      pwr_ok = s_r.pwr_shadow && (s_r.cnt == CNT_DONE);
      adc_req = (req_kind == LSCC_REQ_WRITE) && (req_addr == CTRL_IDX) && req_data[ADC_EN_BIT];
      ctrl_val = s_r.data & CTRL_WR_MASK;
      if (ctrl_val[ADC_EN_BIT]) begin
         ctrl_val[POWER_BIT] = 1'b1;
      end

      if (s_r.pwr_shadow && s_r.cnt != CNT_DONE) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end

      case (s_r.st)
         H_IDLE: begin
            if (req_valid && s_r.ready) begin
               s_nxt.kind = req_kind;
               s_nxt.addr = req_addr;
               s_nxt.data = req_data;
               if (adc_req && !pwr_ok) begin
                  s_nxt.st = s_r.pwr_shadow ? H_WAIT_PWR : H_PRE_CMD;
               end else begin
                  s_nxt.st = H_CMD;
               end
            end
         end
         H_PRE_CMD: begin
            s_nxt.cmd_stb = 1'b1;
            s_nxt.wdata = cmd_byte(CTRL_IDX, TRANS_REPEAT);
            s_nxt.st = H_PRE_DATA;
         end
         H_PRE_DATA: begin
            s_nxt.wr_stb = 1'b1;
            s_nxt.wdata = 8'h01 << POWER_BIT;
            s_nxt.pwr_shadow = 1'b1;
            s_nxt.cnt = '0;
            s_nxt.st = H_WAIT_PWR;
         end
         H_WAIT_PWR: begin
            if (pwr_ok) begin
               s_nxt.st = H_CMD;
            end
         end
         H_CMD: begin
            s_nxt.cmd_stb = 1'b1;
            case (s_r.kind)
               LSCC_REQ_WRITE: begin
                  s_nxt.wdata = cmd_byte(s_r.addr, TRANS_AUTO);
                  s_nxt.st = H_DATA;
               end
               LSCC_REQ_READ: begin
                  s_nxt.wdata = cmd_byte(s_r.addr, TRANS_REPEAT);
                  s_nxt.st = H_RD;
               end
               default: begin
                  s_nxt.wdata = cmd_byte(s_r.addr, TRANS_SPECIAL);
                  s_nxt.resp_valid = 1'b1;
                  s_nxt.st = H_IDLE;
               end
            endcase
         end
         H_DATA: begin
            s_nxt.wr_stb = 1'b1;
            s_nxt.resp_valid = 1'b1;
            s_nxt.st = H_IDLE;
            if (s_r.addr == CTRL_IDX) begin
               s_nxt.wdata = ctrl_val;
               s_nxt.adc_shadow = ctrl_val[ADC_EN_BIT];
               s_nxt.pwr_shadow = ctrl_val[POWER_BIT];
               if (!s_r.pwr_shadow || !ctrl_val[POWER_BIT]) begin
                  s_nxt.cnt = '0;
               end
               if (!ctrl_val[ADC_EN_BIT]) begin
                  s_nxt.cfg_warn = 1'b0;
               end
            end else begin
               s_nxt.wdata = s_r.data;
               if (s_r.adc_shadow) begin
                  s_nxt.cfg_warn = 1'b1;
               end
            end
         end
         H_RD: begin
            s_nxt.rd_stb = 1'b1;
            s_nxt.st = H_WAIT_RD;
         end
         H_WAIT_RD: begin
            if (link.rd_valid) begin
               s_nxt.resp_valid = 1'b1;
               s_nxt.resp_data = link.rdata;
               s_nxt.st = H_IDLE;
            end
         end
         default: begin
            s_nxt.st = H_IDLE;
         end
      endcase

      s_nxt.ready = (s_nxt.st == H_IDLE);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.cmd_stb = s_r.cmd_stb;
   assign link.wr_stb = s_r.wr_stb;
   assign link.rd_stb = s_r.rd_stb;
   assign link.wdata = s_r.wdata;
   assign req_ready = s_r.ready;
   assign resp_valid = s_r.resp_valid;
   assign resp_data = s_r.resp_data;
   assign irq_level = s_r.irq;
   assign cfg_while_running = s_r.cfg_warn;

endmodule : lscc_host

// file: dv/lscc_monitor.sv
`timescale 1ns/1ps
module lscc_monitor
   import lscc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cmd_stb,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] wdata,
   input wire logic rd_valid,
   input wire logic [7:0] rdata,
   input wire logic irq
);
   // Shadow of last command, current index and stored control bits
   logic [7:0] cmd_r;
   logic [4:0] idx_r;
   logic [1:0] ctl_r;
   logic spec;
   assign spec = (cmd_r[6:5] == TRANS_SPECIAL);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_r <= 8'h00;
         idx_r <= 5'h00;
         ctl_r <= 2'h0;
      end else if (cmd_stb) begin
         cmd_r <= wdata;
         idx_r <= wdata[4:0];
      end else if ((wr_stb || rd_stb) && !spec) begin
         if (wr_stb && idx_r == CTRL_IDX) ctl_r <= wdata[1:0];
         if (cmd_r[6:5] == TRANS_AUTO) idx_r <= idx_r + 5'h01;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_ctrl_read;
      rd_stb && !spec && idx_r == CTRL_IDX ##1 rd_valid;
   endsequence
   sequence s_clear;
      cmd_stb && wdata == 8'hE1;
   endsequence
   a_read_answer: assert property (rd_stb && !spec |=> rd_valid)
      else $error("read strobe got no answer");
   a_special_refuse: assert property (rd_stb && spec |=> !rd_valid)
      else $error("read answered after special command");
   a_answer_cause: assert property (rd_valid |-> $past(rd_stb))
      else $error("read answer without strobe");
   a_irq_hold: assert property (irq && !(cmd_stb && wdata == 8'hE1) |=> irq)
      else $error("interrupt dropped without clear");
   a_irq_clear: assert property (s_clear |=> !irq)
      else $error("interrupt not cleared");
   a_ctrl_bits: assert property (s_ctrl_read |-> rdata[1:0] == ctl_r)
      else $error("control bits wrong");
   a_ctrl_reserved: assert property (s_ctrl_read |-> rdata[7:6] == 2'h0 && rdata[3:2] == 2'h0)
      else $error("reserved control bits not zero");
   a_ctrl_intr: assert property (s_ctrl_read |-> rdata[5] == $past(irq))
      else $error("interrupt flag wrong in control");
endmodule : lscc_monitor

// file: dv/lscc_tb.sv
`timescale 1ns/1ps
module lscc_tb;
   import lscc_pkg::*;
   logic sys_clk = 0;
   logic rst_n = 0;
   logic [7:0] integration_time_setting = 8'h00;
   logic adc_done = 0;
   logic int_event = 0;
   logic [7:0] ext_rdata;
   logic power_on, adc_enable, manual_active, int_out, ext_wr;
   logic [4:0] reg_index, ext_idx;
   logic [7:0] ext_wdata;
   logic [15:0] manual_time;
   logic req_valid = 0;
   lscc_req_t req_kind = LSCC_REQ_WRITE;
   logic [4:0] req_addr = 5'h00;
   logic [7:0] req_data = 8'h00;
   logic req_ready, resp_valid, irq_level, cfg_while_running;
   logic [7:0] resp_data, got;
   logic [4:0] seen_idx;
   logic [7:0] seen_d;
   logic [15:0] t0;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int lat;
   always #5 sys_clk = ~sys_clk;
   assign ext_rdata = {3'h5, reg_index};
   lscc_link_if link();
   lscc_dev #(.TIMER_W(16)) i_lscc_dev (.sys_clk, .rst_n, .link(link), .integration_time_setting, .adc_done, .int_event,
      .ext_rdata, .power_on, .adc_enable, .manual_active, .int_out, .reg_index, .ext_wr, .ext_idx,
      .ext_wdata, .manual_time);
   lscc_host #(.PWR_WAIT(20)) i_lscc_host (.sys_clk, .rst_n, .link(link), .req_valid, .req_kind,
      .req_addr, .req_data, .req_ready, .resp_valid, .resp_data, .irq_level, .cfg_while_running);
   lscc_monitor i_lscc_monitor (.sys_clk, .rst_n, .cmd_stb(link.cmd_stb), .wr_stb(link.wr_stb),
      .rd_stb(link.rd_stb), .wdata(link.wdata), .rd_valid(link.rd_valid), .rdata(link.rdata), .irq(link.irq));
   always @(posedge sys_clk) begin
      if (ext_wr === 1'b1) begin
         seen_idx <= ext_idx;
         seen_d <= ext_wdata;
      end
   end
   task automatic print_verdict;
      if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
      n_checks++;
      if (seen !== exp) begin
         $display("FAIL %s expected %h seen %h", name, exp, seen);
         bad_count++;
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic do_req(input lscc_req_t k, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req_kind = k;
      req_addr = a;
      req_data = d;
      req_valid = 1;
      while (req_ready !== 1'b1) tick(1);
      tick(1);
      req_valid = 0;
      while (resp_valid !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      lat = n;
      got = resp_data;
      chk("response", 1'b1, resp_valid);
   endtask : do_req
   task automatic t_reset;
      chk("power", 0, power_on);
      chk("index", 0, reg_index);
      do_req(LSCC_REQ_READ, CTRL_IDX, 8'h00);
      chk("ctrl", 8'h00, got);
   endtask : t_reset
   task automatic t_ctrl;
      do_req(LSCC_REQ_WRITE, CTRL_IDX, 8'h03);
      tick(1);
      chk("wait", 1, lat >= 20);
      chk("power", 1, power_on);
      chk("adc", 1, adc_enable);
      do_req(LSCC_REQ_WRITE, CTRL_IDX, 8'hFF);
      do_req(LSCC_REQ_READ, CTRL_IDX, 8'h00);
      chk("ctrl", 8'h03, got);
      do_req(LSCC_REQ_WRITE, CTRL_IDX, 8'h01);
      tick(1);
      chk("adc", 0, adc_enable);
   endtask : t_ctrl
   task automatic t_irq;
      int_event = 1;
      tick(1);
      int_event = 0;
      tick(6);
      chk("irq", 1, irq_level);
      do_req(LSCC_REQ_READ, CTRL_IDX, 8'h00);
      chk("ctrl", 8'h21, got);
      do_req(LSCC_REQ_SPECIAL, SF_INT_CLEAR, 8'h00);
      tick(3);
      chk("irq", 0, int_out);
      chk("index", CTRL_IDX, reg_index);
   endtask : t_irq
   task automatic t_manual;
      integration_time_setting = 8'hFF;
      do_req(LSCC_REQ_SPECIAL, SF_START_MANUAL, 8'h00);
      tick(2);
      chk("manual", 0, manual_active);
      integration_time_setting = INTEGRATION_TIME_SETTING_MANUAL;
      do_req(LSCC_REQ_SPECIAL, SF_START_MANUAL, 8'h00);
      tick(2);
      chk("manual", 1, manual_active);
      tick(10);
      do_req(LSCC_REQ_SPECIAL, SF_STOP_MANUAL, 8'h00);
      tick(2);
      chk("manual", 0, manual_active);
      t0 = manual_time;
      chk("span", 1, t0 >= 16'd10 && t0 <= 16'd40);
      do_req(LSCC_REQ_READ, TIMER_LO_IDX, 8'h00);
      chk("timer", t0[7:0], got);
      do_req(LSCC_REQ_READ, CTRL_IDX, 8'h00);
      chk("ctrl", 8'h11, got);
   endtask : t_manual
   task automatic t_index;
      do_req(LSCC_REQ_WRITE, 5'h07, 8'h5A);
      tick(2);
      chk("ext idx", 5'h07, seen_idx);
      chk("ext data", 8'h5A, seen_d);
      chk("index", 5'h08, reg_index);
      chk("cfg", 0, cfg_while_running);
      do_req(LSCC_REQ_READ, 5'h14, 8'h00);
      chk("ext read", 8'hB4, got);
      chk("index", 5'h14, reg_index);
      do_req(LSCC_REQ_WRITE, CTRL_IDX, 8'h01);
      do_req(LSCC_REQ_READ, CTRL_IDX, 8'h00);
      chk("ctrl", 8'h01, got);
      do_req(LSCC_REQ_WRITE, CTRL_IDX, 8'h03);
      adc_done = 1;
      tick(1);
      adc_done = 0;
      do_req(LSCC_REQ_READ, CTRL_IDX, 8'h00);
      chk("ctrl", 8'h13, got);
      do_req(LSCC_REQ_WRITE, 5'h07, 8'hA5);
      chk("cfg", 1, cfg_while_running);
   endtask : t_index
   initial begin
      tick(4);
      rst_n = 1;
      tick(1);
      t_reset();
      t_ctrl();
      t_irq();
      t_manual();
      t_index();
      print_verdict();
   end
endmodule : lscc_tb
